// File: design/axis_run_pkg.sv
// Shared constants and types for the axis mode and run status block
package axis_run_pkg;
   // Bus geometry
   localparam int          ADDR_W          = 12;
   localparam int          DATA_W          = 32;
   // Global register byte offsets
   localparam logic [11:0] CMD_OFF         = 12'h000;
   localparam logic [11:0] IRQ_STAT_OFF    = 12'h004;
   localparam logic [11:0] IRQ_CLR_OFF     = 12'h008;
   localparam logic [11:0] IRQ_EN_OFF      = 12'h00C;
   // Per-axis register window: base plus axis times stride
   localparam logic [11:0] AXIS_BASE       = 12'h040;
   localparam int          AXIS_SH         = 4;
   localparam logic [3:0]  AX_MODE_OFF     = 4'h0;
   localparam logic [3:0]  AX_PULSE_OFF    = 4'h4;
   localparam logic [3:0]  AX_SEQ_OFF      = 4'h8;
   localparam logic [3:0]  AX_STAT_OFF     = 4'hC;
   // Operation mode word codes
   localparam logic [15:0] MODE_ABS_CODE   = 16'h0000;
   localparam logic [15:0] MODE_REL_CODE   = 16'h00FF;
   localparam logic [7:0]  MODE_VEL_HIGH   = 8'hFF;
   // Scaling order codes (0 and -1 as a 16-bit word)
   localparam logic [15:0] SEQ_MUL_CODE    = 16'h0000;
   localparam logic [15:0] SEQ_DIV_CODE    = 16'hFFFF;
   // Reset values
   localparam logic [15:0] MODE_RST        = 16'h0000;
   localparam logic [15:0] PULSE_RST       = 16'h0000;
   // Per-axis status word layout
   localparam int          STAT_RUN_BIT    = 0;
   localparam int          STAT_MODE_LSB   = 1;
   localparam int          STAT_LOAD_LSB   = 3;
   localparam int          STAT_DIR_BIT    = 5;
   localparam int          STAT_DIV_BIT    = 6;
   localparam int          STAT_CNT_LSB    = 16;
   // Run/stop update period
   localparam int          CLK_HZ          = 125_000_000;
   localparam int          TICK_MS         = 20;
   localparam int          TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
   // Decoded operation mode
   typedef enum logic [1:0] {MODE_ABS, MODE_REL, MODE_VEL} mode_t;
endpackage : axis_run_pkg

// File: design/axis_mode_and_run_status.sv
// Per-axis operation mode, run/stop status stretch and scaling order, APB slave
// Function
// RL1 - Mode word 0000 absolute, 00FF relative, FFxx velocity.
// RL2 - Absolute mode: target measured from axis origin.
// RL3 - Relative mode: target is offset from present position.
// RL4 - Velocity mode: accelerate to velocity, hold until stop, limit, change.
// RL5 - Mode kept per axis, written anytime, applied at next start.
// RL6 - Servo: parameters loaded before mode change keep old meaning.
// RL7 - Stepper velocity mode: target sign sets direction, +1 forward.
// RL8 - Minimum run pulse is 16-bit count of update periods.
// RL9 - Count zero: no stretching, true status shown directly.
// RL10 - Count one: run forced for about one 20 ms period.
// RL11 - Start forces run at once, held for minimum pulse.
// RL12 - After pulse, run comes from position change each 20 ms.
// RL13 - Run shown for full pulse even on zero-length move.
// RL14 - Scaling order: 0 multiply first, -1 divide first.
// RL15 - Order writable anytime, effective only with non-unity scale factors.
// RL16 - Open-loop stepper rejects order command with function error.
// RL17 - Closed-loop stepper applies order in both loop modes.
// RL18 - Each start reloads stretch counter, restarting any running stretch.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module axis_mode_and_run_status
   import axis_run_pkg::*;
#(
   parameter int NUM_AXES    = 4,
   parameter int POS_W       = 32,
   parameter int TICK_CYCLES = TICK_CYCLES_DEF,
   parameter bit CLOSED_LOOP = 1'b1,
   parameter bit STEPPER     = 1'b0
)(
   // Clock and reset
   input  wire logic                           core_clk,
   input  wire logic                           rst_n,
   // APB slave
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [ADDR_W-1:0]              paddr,
   input  wire logic [DATA_W-1:0]              pwdata,
   output logic      [DATA_W-1:0]              prdata,
   output logic                                pready,
   output logic                                pslverr,
   // Motion core side, same clock
   input  wire logic [NUM_AXES-1:0][POS_W-1:0] axisPos,
   input  wire logic [NUM_AXES-1:0]            targetLoad,
   input  wire logic [NUM_AXES-1:0]            targetNeg,
   input  wire logic [NUM_AXES-1:0]            scaleActive,
   // Per-axis results and the shared start strobe
   output logic      [NUM_AXES-1:0]            runStatus,
   output mode_t     [NUM_AXES-1:0]            activeMode,
   output mode_t     [NUM_AXES-1:0]            loadMode,
   output logic      [NUM_AXES-1:0]            dirReverse,
   output logic      [NUM_AXES-1:0]            divFirst,
   output logic                                startPulse,
   // Interrupt
   output logic                                irq
);
   localparam int TW  = $clog2(TICK_CYCLES + 1);
   localparam int EVW = 2 * NUM_AXES + 1;
   localparam int IW  = ADDR_W - AXIS_SH;

   typedef struct packed {
      logic [NUM_AXES-1:0][15:0]    modeWord;
      logic [NUM_AXES-1:0][15:0]    pulse;
      logic [NUM_AXES-1:0]          seqDiv;
      mode_t [NUM_AXES-1:0]         activeMode;
      mode_t [NUM_AXES-1:0]         loadMode;
      logic [NUM_AXES-1:0]          dirReverse;
      logic [NUM_AXES-1:0]          run;
      logic [NUM_AXES-1:0][15:0]    stretch;
      logic [NUM_AXES-1:0][POS_W-1:0] lastPos;
      logic [NUM_AXES-1:0]          divFirst;
      logic                         startPulse;
      logic [TW-1:0]                tickCnt;
      logic                         tick;
      logic [EVW-1:0]               irqStat;
      logic [EVW-1:0]               irqEn;
      logic                         irq;
      logic                         pready;
      logic                         pslverr;
      logic [DATA_W-1:0]            prdata;
   } state_t;

   state_t s;
   state_t next_s;

   // Mode word decode; only the three legal patterns are accepted
   function automatic mode_t modeDecode(input logic [15:0] w);
      if (w[15:8] == MODE_VEL_HIGH)
         return MODE_VEL;
      else if (w == MODE_REL_CODE)
         return MODE_REL;
      else
         return MODE_ABS;
   endfunction : modeDecode

   function automatic logic modeLegal(input logic [15:0] w);
      return (w[15:8] == MODE_VEL_HIGH) || (w == MODE_REL_CODE) || (w == MODE_ABS_CODE);
   endfunction : modeLegal

   // Bus decode
   logic          xfer;
   logic          commit;
   logic          wrCommit;
   logic [IW-1:0] axIdx;
   logic          axisHit;
   logic [3:0]    regOff;
   logic          globalHit;
   logic          badAccess;

   assign xfer      = psel & penable;
   assign commit    = xfer & s.pready;
   assign wrCommit  = commit & pwrite;
   assign axIdx     = paddr[ADDR_W-1:AXIS_SH] - AXIS_BASE[ADDR_W-1:AXIS_SH];
   assign axisHit   = (paddr >= AXIS_BASE) && (axIdx < IW'(NUM_AXES));
   assign regOff    = paddr[AXIS_SH-1:0];
   assign globalHit = (paddr == CMD_OFF) || (paddr == IRQ_STAT_OFF)
                      || (paddr == IRQ_CLR_OFF) || (paddr == IRQ_EN_OFF);

   // Refused accesses: unmapped, read-only writes, illegal codes
   always_comb
   begin
      badAccess = !(globalHit || axisHit);
      if (pwrite && paddr == IRQ_STAT_OFF)
         badAccess = 1'b1;
      if (pwrite && axisHit)
      begin
         unique case (regOff)
            AX_MODE_OFF:  badAccess = !modeLegal(pwdata[15:0]);
            AX_PULSE_OFF: badAccess = 1'b0;
            AX_SEQ_OFF:   badAccess = !CLOSED_LOOP //RL16
                                      || !(pwdata[15:0] == SEQ_MUL_CODE
                                           || pwdata[15:0] == SEQ_DIV_CODE);
            default:      badAccess = 1'b1;
         endcase
      end
   end

   // Next-state logic for the whole block
   always_comb
   begin
      logic [EVW-1:0]    ev;
      logic              moved;
      logic [DATA_W-1:0] rd;
      ev     = '0;
      moved  = 1'b0;
      rd     = '0;
      next_s = s;

      // Update period timer; the tick paces stretch and motion sampling
      next_s.tick = 1'b0;
      if (s.tickCnt == TW'(TICK_CYCLES - 1))
      begin
         next_s.tickCnt = '0;
         next_s.tick    = 1'b1;
      end
      else
         next_s.tickCnt = s.tickCnt + 1'b1;

      next_s.startPulse = wrCommit && !badAccess && (paddr == CMD_OFF)
                          && (|pwdata[NUM_AXES-1:0]);

      for (int i = 0; i < NUM_AXES; i++)
      begin
         // Register writes per axis, only when not refused
         if (wrCommit && !badAccess && axisHit && axIdx == IW'(i))
         begin
            if (regOff == AX_MODE_OFF)
               next_s.modeWord[i] = pwdata[15:0]; //RL5
            if (regOff == AX_PULSE_OFF)
               next_s.pulse[i] = pwdata[15:0]; //RL8
            if (regOff == AX_SEQ_OFF)
               next_s.seqDiv[i] = (pwdata[15:0] == SEQ_DIV_CODE); //RL14
         end

         // Target load latches the meaning in force at load time
         if (targetLoad[i])
         begin
            next_s.loadMode[i] = modeDecode(s.modeWord[i]); //RL6
            // Absolute vs relative reference follows loadMode //RL2
            // Relative loads become offsets from position at use //RL3
            if (STEPPER && modeDecode(s.modeWord[i]) == MODE_VEL)
               next_s.dirReverse[i] = targetNeg[i]; //RL7
         end

         // Position change since the last update period
         moved = (axisPos[i] != s.lastPos[i]);
         if (s.tick)
            next_s.lastPos[i] = axisPos[i]; //RL12

         // Start forces run and reloads the stretch counter
         if (wrCommit && !badAccess && paddr == CMD_OFF && pwdata[i])
         begin
            next_s.activeMode[i] = modeDecode(s.modeWord[i]); //RL1
            // Velocity mode holds speed until stop or limit //RL4
            next_s.run[i]        = 1'b1; //RL11
            next_s.stretch[i]    = s.pulse[i]; //RL18
            ev[i]                = 1'b1;
         end
         else if (s.tick)
         begin
            if (s.stretch[i] != '0)
               next_s.stretch[i] = s.stretch[i] - 1'b1; //RL13
            else
               next_s.run[i] = moved; //RL9
         end
         // A count of one holds run for at least one full period //RL10

         if (s.run[i] && !next_s.run[i])
            ev[NUM_AXES + i] = 1'b1;

         // Order takes effect only with non-unity factors loaded
         next_s.divFirst[i] = s.seqDiv[i] & scaleActive[i]; //RL15
         // Loop mode is not looked at: both loop modes use it //RL17
      end

      // Refused write is reported as a function error event
      if (wrCommit && badAccess)
         ev[2 * NUM_AXES] = 1'b1; //RL16

      // Sticky status, set wins over a same-cycle clear
      if (wrCommit && paddr == IRQ_CLR_OFF)
         next_s.irqStat = (s.irqStat & ~pwdata[EVW-1:0]) | ev;
      else
         next_s.irqStat = s.irqStat | ev;
      if (wrCommit && paddr == IRQ_EN_OFF)
         next_s.irqEn = pwdata[EVW-1:0];
      next_s.irq = |(next_s.irqStat & next_s.irqEn);

      // Read mux; clear and command registers read as zero
      if (paddr == IRQ_STAT_OFF)
         rd = DATA_W'(s.irqStat);
      else if (paddr == IRQ_EN_OFF)
         rd = DATA_W'(s.irqEn);
      else if (axisHit)
      begin
         for (int i = 0; i < NUM_AXES; i++)
         begin
            if (axIdx == IW'(i))
            begin
               unique case (regOff)
                  AX_MODE_OFF:  rd = DATA_W'(s.modeWord[i]);
                  AX_PULSE_OFF: rd = DATA_W'(s.pulse[i]);
                  AX_SEQ_OFF:   rd = s.seqDiv[i] ? DATA_W'(SEQ_DIV_CODE) : '0;
                  default:
                  begin
                     rd[STAT_RUN_BIT]                    = s.run[i];
                     rd[STAT_MODE_LSB +: 2]              = s.activeMode[i];
                     rd[STAT_LOAD_LSB +: 2]              = s.loadMode[i];
                     rd[STAT_DIR_BIT]                    = s.dirReverse[i];
                     rd[STAT_DIV_BIT]                    = s.divFirst[i];
                     rd[STAT_CNT_LSB +: 16]              = s.stretch[i];
                  end
               endcase
            end
         end
      end

      // One wait state: ready rises on the second access cycle
      next_s.pready  = xfer & ~s.pready;
      next_s.pslverr = xfer & ~s.pready & badAccess;
      next_s.prdata  = (xfer & ~s.pready & ~pwrite & ~badAccess) ? rd : '0;
   end

   // State register, synchronous reset
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         s          <= '0;
         s.modeWord <= {NUM_AXES{MODE_RST}};
         s.pulse    <= {NUM_AXES{PULSE_RST}};
      end
      else
         s <= next_s;
   end

   // Outputs straight from state
   assign prdata     = s.prdata;
   assign pready     = s.pready;
   assign pslverr    = s.pslverr;
   assign runStatus  = s.run;
   assign activeMode = s.activeMode;
   assign loadMode   = s.loadMode;
   assign dirReverse = s.dirReverse;
   assign divFirst   = s.divFirst;
   assign startPulse = s.startPulse;
   assign irq        = s.irq;

   // Checks on axis 0, the bus and the interrupt
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   logic startAx0;
   assign startAx0 = wrCommit && !badAccess && paddr == CMD_OFF && pwdata[0];

   property p_start_run;
      startAx0 |=> s.run[0] && s.stretch[0] == $past(s.pulse[0]);
   endproperty
   a_start_run: assert property (p_start_run) //RL11
      else $error("start did not force run with reloaded count");

   property p_stretch_hold;
      s.run[0] && s.stretch[0] != '0 && !startAx0 |=> s.run[0];
   endproperty
   a_stretch_hold: assert property (p_stretch_hold) //RL13
      else $error("run dropped while stretch counting");

   property p_true_status;
      s.tick && s.stretch[0] == '0 && !startAx0
         |=> s.run[0] == ($past(axisPos[0]) != $past(s.lastPos[0]));
   endproperty
   a_true_status: assert property (p_true_status) //RL12
      else $error("run does not follow position change after stretch");

   property p_mode_decode;
      startAx0 |=> s.activeMode[0] ==
         (($past(s.modeWord[0][15:8]) == MODE_VEL_HIGH) ? MODE_VEL :
          ($past(s.modeWord[0]) == MODE_REL_CODE) ? MODE_REL : MODE_ABS);
   endproperty
   a_mode_decode: assert property (p_mode_decode) //RL1
      else $error("active mode decode wrong at start");

   property p_mode_deferred;
      !startAx0 |=> $stable(s.activeMode[0]);
   endproperty
   a_mode_deferred: assert property (p_mode_deferred) //RL5
      else $error("active mode changed without a start");

   property p_order;
      ##1 divFirst[0] == $past(s.seqDiv[0] & scaleActive[0]);
   endproperty
   a_order: assert property (p_order) //RL15
      else $error("scaling order not gated by scale factors");

   property p_reject_seq;
      pready && psel && pwrite && axisHit && regOff == AX_SEQ_OFF && !CLOSED_LOOP
         |-> pslverr ##1 s.irqStat[2 * NUM_AXES];
   endproperty
   a_reject_seq: assert property (p_reject_seq) //RL16
      else $error("order command not refused on open-loop board");

   property p_stretch_count;
      s.tick && s.stretch[0] != '0 && !startAx0
         |=> s.stretch[0] == $past(s.stretch[0]) - 16'h0001;
   endproperty
   a_stretch_count: assert property (p_stretch_count) //RL8
      else $error("stretch count did not step once per period");

   // Ready stands one cycle only, so a held request cannot commit on two cycles in a row
   property p_ready_one;
      pready |=> !pready;
   endproperty
   a_ready_one: assert property (p_ready_one)
      else $error("ready held longer than one cycle");

   // Error only ever rides on a ready cycle
   property p_err_ready;
      pslverr |-> pready;
   endproperty
   a_err_ready: assert property (p_err_ready)
      else $error("error flagged outside a ready cycle");

   // Load latches the mode in force at that moment, not the later one
   property p_load_mode;
      targetLoad[0] |=> loadMode[0] == $past(modeDecode(s.modeWord[0]));
   endproperty
   a_load_mode: assert property (p_load_mode) //RL6
      else $error("load did not capture the mode in force");

   // Stepper velocity load takes direction from the target sign
   property p_dir_load;
      targetLoad[0] && modeDecode(s.modeWord[0]) == MODE_VEL
         |=> dirReverse[0] == (STEPPER ? $past(targetNeg[0]) : $past(dirReverse[0]));
   endproperty
   a_dir_load: assert property (p_dir_load) //RL7
      else $error("direction not taken from target sign");

   property p_irq;
      ##1 irq == |(s.irqStat & s.irqEn);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt output disagrees with status and enable");
endmodule : axis_mode_and_run_status

// File: dv/axis_mode_and_run_status_tb.sv
// Self-checking bench for the axis mode and run status block
`timescale 1ns/1ps
module axis_mode_and_run_status_tb;
   import axis_run_pkg::*;
   localparam int T = 16;
   typedef struct {logic [11:0] a; logic [31:0] d; logic e; logic r; logic re; logic [31:0] q;} row_t;
   logic                 core_clk, rst_n, psel, penable, pwrite;
   logic [11:0]          paddr;
   logic [31:0]          pwdata, prdata, rdv;
   logic                 pready, pslverr, pslverrOpen, errv, errOpen;
   logic [3:0][31:0]     axisPos;
   logic [3:0]           targetLoad, targetNeg, scaleActive, runStatus, dirReverse, divFirst;
   mode_t [3:0]          activeMode, loadMode;
   logic                 startPulse, irq, moving;
   int                   fail_count, total_checks, n;
   row_t                 rows[12];

   // Closed-loop stepper variant under test
   axis_mode_and_run_status #(.TICK_CYCLES(T), .CLOSED_LOOP(1'b1),
      .STEPPER(1'b1)) dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .axisPos(axisPos), .targetLoad(targetLoad), .targetNeg(targetNeg),
      .scaleActive(scaleActive), .runStatus(runStatus), .activeMode(activeMode),
      .loadMode(loadMode), .dirReverse(dirReverse), .divFirst(divFirst),
      .startPulse(startPulse), .irq(irq));
   // Open-loop variant on the same bus, only its error answer is watched
   axis_mode_and_run_status #(.TICK_CYCLES(T), .CLOSED_LOOP(1'b0),
      .STEPPER(1'b1)) openLoop (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
      .pready(), .pslverr(pslverrOpen), .axisPos(axisPos), .targetLoad(targetLoad),
      .targetNeg(targetNeg), .scaleActive(scaleActive), .runStatus(), .activeMode(),
      .loadMode(), .dirReverse(), .divFirst(), .startPulse(), .irq());

   // Clock, 8 ns period
   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // Axis 2 creeps forward while moving is set; all axes rest at zero in reset
   always @(posedge core_clk)
      if (!rst_n)
         axisPos <= '0;
      else if (moving)
         axisPos[2] <= axisPos[2] + 32'h1;

   task finish_test;
      if (fail_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test

   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [11:0] ra(input int ax, input logic [3:0] off);
      return AXIS_BASE + 12'(ax << AXIS_SH) + {8'h00, off};
   endfunction : ra

   // One APB transfer; waits for pready, bounded so a hang ends the run
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20)
      begin
         fail_count++;
         $display("unexpected at %0t: no bus answer", $time);
         finish_test();
      end
      rdv = prdata;
      errv = pslverr;
      errOpen = pslverrOpen;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb

   // Cycles that run stays high, counted from now
   task runlen(input int ax);
      n = 0;
      while (runStatus[ax] === 1'b1 && n < 2000)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
   endtask : runlen

   // One-cycle target load strobe on one axis
   task load(input int ax, input logic neg);
      @(posedge core_clk);
      targetLoad[ax] <= 1'b1;
      targetNeg[ax] <= neg;
      @(posedge core_clk);
      targetLoad <= 4'h0;
      repeat (2) @(posedge core_clk);
      #1;
   endtask : load

   initial
   begin
      {rst_n, psel, penable, pwrite, moving} = 5'h00;
      {paddr, pwdata} = '0;
      {targetLoad, targetNeg, scaleActive} = 12'h000;
      {fail_count, total_checks} = 0;
      rows = '{'{ra(0,AX_MODE_OFF), 32'h0000, 0, 1, 0, 32'h0000},
               '{ra(1,AX_MODE_OFF), 32'h00FF, 0, 1, 0, 32'h00FF},
               '{ra(2,AX_MODE_OFF), 32'hFF3C, 0, 1, 0, 32'hFF3C},
               '{ra(3,AX_MODE_OFF), 32'h0012, 1, 1, 0, 32'h0000},
               '{ra(0,AX_SEQ_OFF), 32'hFFFF, 0, 1, 0, 32'h0000FFFF},
               '{ra(1,AX_SEQ_OFF), 32'h0001, 1, 1, 0, 32'h0000},
               '{ra(0,AX_PULSE_OFF), 32'hFFFF, 0, 1, 0, 32'hFFFF},
               '{ra(1,AX_PULSE_OFF), 32'h0002, 0, 1, 0, 32'h0002},
               '{ra(3,AX_PULSE_OFF), 32'h0001, 0, 1, 0, 32'h0001},
               '{IRQ_STAT_OFF, 32'h1, 1, 0, 0, 32'h0},
               '{ra(3,AX_STAT_OFF), 32'h1, 1, 0, 0, 32'h0},
               '{12'h800, 32'h5, 1, 1, 1, 32'h0}};
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      // Power-up defaults
      apb(1'b0, ra(3,AX_MODE_OFF), 32'h0);
      chk(rdv, {16'h0, MODE_RST});
      apb(1'b0, ra(3,AX_PULSE_OFF), 32'h0);
      chk(rdv, {16'h0, PULSE_RST});
      apb(1'b0, ra(3,AX_SEQ_OFF), 32'h0);
      chk(rdv, {16'h0, SEQ_MUL_CODE});
      chk({runStatus, divFirst, irq}, 9'h000);
      // Table of register writes, refusals and readbacks
      foreach (rows[i])
      begin
         apb(1'b1, rows[i].a, rows[i].d);
         chk(errv, rows[i].e);
         if (rows[i].r)
         begin
            apb(1'b0, rows[i].a, 32'h0);
            chk(errv, rows[i].re);
            chk(rdv, rows[i].q);
         end
      end
      // Order only matters once non-unity scale factors are loaded
      chk(divFirst, 4'h0);
      @(posedge core_clk);
      scaleActive <= 4'hF;
      repeat (3) @(posedge core_clk);
      #1;
      chk(divFirst, 4'b0001);
      // Start axes 0 and 2 together, axis 2 moving with no stretch
      @(posedge core_clk);
      moving <= 1'b1;
      apb(1'b1, CMD_OFF, 32'h5);
      chk(startPulse, 1'b1);
      chk({activeMode[2], activeMode[0]}, {MODE_VEL, MODE_ABS});
      chk({runStatus[2], runStatus[0]}, 2'b11);
      repeat (4 * T) @(posedge core_clk);
      #1;
      chk(runStatus[2], 1'b1);
      chk(startPulse, 1'b0);
      @(posedge core_clk);
      moving <= 1'b0;
      #1;
      runlen(2);
      chk(n <= 2 * T + 2, 1'b1);
      // Count one, zero-length move on axis 3
      apb(1'b1, CMD_OFF, 32'h8);
      chk({runStatus[3], activeMode[3]}, {1'b1, MODE_ABS});
      runlen(3);
      chk(n >= T && n <= 2 * T + 2, 1'b1);
      // Restart in mid-stretch, mode change applied only at start
      apb(1'b1, CMD_OFF, 32'h2);
      repeat (T) @(posedge core_clk);
      apb(1'b1, ra(1,AX_MODE_OFF), 32'hFF00);
      chk(activeMode[1], MODE_REL);
      apb(1'b1, CMD_OFF, 32'h2);
      chk(activeMode[1], MODE_VEL);
      runlen(1);
      chk(n >= 2 * T && n <= 3 * T + 2, 1'b1);
      // Load meaning fixed at load time, sign gives direction
      load(1, 1'b1);
      chk({loadMode[1], dirReverse[1]}, {MODE_VEL, 1'b1});
      apb(1'b1, ra(1,AX_MODE_OFF), 32'h0000);
      chk(loadMode[1], MODE_VEL);
      load(1, 1'b0);
      chk(loadMode[1], MODE_ABS);
      // Both signs on a velocity axis: reverse, then back to forward
      apb(1'b1, ra(0,AX_MODE_OFF), 32'hFF00);
      load(0, 1'b1);
      chk({loadMode[0], dirReverse[0]}, {MODE_VEL, 1'b1});
      load(0, 1'b0);
      chk(dirReverse[0], 1'b0);
      // Order command on both variants
      apb(1'b1, ra(2,AX_SEQ_OFF), 32'h0);
      chk({errv, errOpen}, 2'b01);
      // Start and function error status, masking, enable and clear
      apb(1'b0, IRQ_STAT_OFF, 32'h0);
      chk({rdv[8], rdv[1]}, 2'b11);
      chk(irq, 1'b0);
      apb(1'b1, IRQ_EN_OFF, 32'h100);
      chk(irq, 1'b1);
      apb(1'b1, IRQ_CLR_OFF, 32'h100);
      chk(irq, 1'b0);
      // Reset in mid-run returns defaults
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      chk({runStatus, irq}, 5'h00);
      @(posedge core_clk);
      rst_n <= 1'b1;
      apb(1'b0, ra(2,AX_MODE_OFF), 32'h0);
      chk(rdv, {16'h0, MODE_RST});
      finish_test();
   end
endmodule : axis_mode_and_run_status_tb
